// ===== hdl/asrq_pkg.sv
package asrq_pkg;

    // ******************************************************
    // oversampling and framing
    // ******************************************************
    localparam logic [6:0] BIT_LEN_16 = 7'h10;
    localparam logic [6:0] BIT_LEN_64 = 7'h40;
    // a start bit is taken one sample past its nominal centre
    localparam logic [6:0] QUAL_16 = 7'(BIT_LEN_16 / 2 + 1);
    localparam logic [6:0] QUAL_64 = 7'(BIT_LEN_64 / 2 + 1);
    // low runs shorter than this are surely rejected as noise
    localparam logic [6:0] IGN_16 = 7'h07;
    localparam logic [6:0] IGN_64 = 7'h1F;
    localparam logic [3:0] DATA_MIN = 4'h5;
    localparam logic [3:0] DATA_MAX = 4'h8;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    // status must be visible within this many main clocks
    localparam int STATUS_DELAY_MAX = 28;

    // ******************************************************
    // carriers
    // ******************************************************
    typedef struct packed {
        logic mode_64x;
        logic parity_en;
        logic parity_odd;
        logic [1:0] data_len;
    } asrq_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic frame_err;
        logic parity_err;
    } asrq_char_t;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_START = 7'h02,
        S_DATA = 7'h04,
        S_PAR = 7'h08,
        S_STOP = 7'h10,
        S_HOLD = 7'h20,
        S_BREAK = 7'h40
    } asrq_fsm_t;

endpackage

// ===== hdl/asrq_rx.sv
// Contract
// - 16x: low under 7 clocks is ignored
// - 64x: low under 31 clocks is ignored
// - 16x: low 9 to 16 clocks starts character
// - 64x: low 33 to 64 clocks starts character
// - exact half-bit start pulses are unreliable
// - break ending before parity sets parity flag only
// - parity flag stays set until cleared
// - break ending elsewhere sets no flag, no ready
// - status updates within 28 main clocks
`timescale 1ns/10ps
`default_nettype none

module asrq_rx (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial line
    input wire logic serial_in,
    input wire logic rx_oversample_clock,
    // configuration
    input wire asrq_pkg::asrq_cfg_t cfg,
    // status
    input wire logic err_clr,
    output logic parity_err,
    output logic framing_err,
    output logic rx_char_ready,
    // character stream
    output asrq_pkg::asrq_char_t rx_word,
    output logic rx_valid,
    input wire logic rx_ready
);

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        asrq_pkg::asrq_fsm_t fsm;
        logic osc_prev;
        logic [6:0] tick;
        logic [3:0] pos;
        logic [7:0] shift;
        logic par;
        logic ones;
        logic pbad;
        asrq_pkg::asrq_char_t pend;
        asrq_pkg::asrq_char_t buf0;
        asrq_pkg::asrq_char_t buf1;
        logic [1:0] cnt;
        logic rdy;
        logic perr;
        logic ferr;
    } asrq_state_t;

    localparam asrq_state_t ST_RESET = '{
        fsm: asrq_pkg::S_IDLE,
        default: '0
    };

    asrq_state_t st_r;
    asrq_state_t st_nxt;

    logic osc_edge;
    logic [6:0] bit_len;
    logic [6:0] qual;
    logic [3:0] nd;
    logic [3:0] brk_last;
    logic push;
    logic pop;
    logic perr_set;
    logic ferr_set;
    logic brk_end;
    logic brk_par;
    logic [1:0] cnt_tmp;

    assign osc_edge = rx_oversample_clock & ~st_r.osc_prev;
    assign bit_len = cfg.mode_64x ? asrq_pkg::BIT_LEN_64
                                  : asrq_pkg::BIT_LEN_16;
    assign qual = cfg.mode_64x ? asrq_pkg::QUAL_64 : asrq_pkg::QUAL_16;
    assign nd = asrq_pkg::DATA_MIN + {2'h0, cfg.data_len};
    // last sample index of a frame counted from the start slot
    assign brk_last = nd + {3'h0, cfg.parity_en} + 4'h1;

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.osc_prev = rx_oversample_clock;
        push = 1'b0;
        perr_set = 1'b0;
        ferr_set = 1'b0;
        brk_end = 1'b0;
        brk_par = 1'b0;
        cnt_tmp = st_r.cnt;
        case (st_r.fsm)
            asrq_pkg::S_IDLE: begin
                if (osc_edge && !serial_in) begin
                    st_nxt.tick = 7'h01;
                    st_nxt.fsm = asrq_pkg::S_START;
                end
            end
            asrq_pkg::S_START: begin
                if (osc_edge) begin
                    if (serial_in) begin
                        // high before qualification: noise, restart
                        st_nxt.tick = 7'h00;
                        st_nxt.fsm = asrq_pkg::S_IDLE;
                    end else if (st_r.tick == qual - 7'h01) begin
                        // half bit plus one; exactly half never passes
                        st_nxt.tick = 7'h00;
                        st_nxt.pos = 4'h0;
                        st_nxt.shift = 8'h00;
                        st_nxt.par = 1'b0;
                        st_nxt.ones = 1'b0;
                        st_nxt.pbad = 1'b0;
                        st_nxt.fsm = asrq_pkg::S_DATA;
                    end else begin
                        st_nxt.tick = st_r.tick + 7'h01;
                    end
                end
            end
            asrq_pkg::S_DATA: begin
                if (osc_edge) begin
                    if (st_r.tick == bit_len - 7'h01) begin
                        st_nxt.tick = 7'h00;
                        st_nxt.shift = {serial_in, st_r.shift[7:1]};
                        st_nxt.par = st_r.par ^ serial_in;
                        st_nxt.ones = st_r.ones | serial_in;
                        st_nxt.pos = st_r.pos + 4'h1;
                        if (st_r.pos + 4'h1 == nd) begin
                            st_nxt.fsm = cfg.parity_en ? asrq_pkg::S_PAR
                                                       : asrq_pkg::S_STOP;
                        end
                    end else begin
                        st_nxt.tick = st_r.tick + 7'h01;
                    end
                end
            end
            asrq_pkg::S_PAR: begin
                if (osc_edge) begin
                    if (st_r.tick == bit_len - 7'h01) begin
                        st_nxt.tick = 7'h00;
                        st_nxt.pbad = st_r.par ^ serial_in ^ cfg.parity_odd;
                        st_nxt.ones = st_r.ones | serial_in;
                        st_nxt.fsm = asrq_pkg::S_STOP;
                    end else begin
                        st_nxt.tick = st_r.tick + 7'h01;
                    end
                end
            end
            asrq_pkg::S_STOP: begin
                if (osc_edge) begin
                    if (st_r.tick == bit_len - 7'h01) begin
                        st_nxt.tick = 7'h00;
                        if (!serial_in && !st_r.ones) begin
                            // all-zero frame: a break, no character
                            st_nxt.pos = 4'h0;
                            st_nxt.fsm = asrq_pkg::S_BREAK;
                        end else begin
                            st_nxt.pend.data = st_r.shift >> (
                                asrq_pkg::DATA_MAX - nd);
                            st_nxt.pend.frame_err = ~serial_in;
                            st_nxt.pend.parity_err = st_r.pbad;
                            perr_set = st_r.pbad;
                            ferr_set = ~serial_in;
                            st_nxt.fsm = asrq_pkg::S_HOLD;
                        end
                    end else begin
                        st_nxt.tick = st_r.tick + 7'h01;
                    end
                end
            end
            asrq_pkg::S_HOLD: begin
                // the line cannot be stalled; a late drain costs frames
                if (st_r.cnt != asrq_pkg::BUF_DEPTH) begin
                    push = 1'b1;
                    st_nxt.fsm = asrq_pkg::S_IDLE;
                end
            end
            asrq_pkg::S_BREAK: begin
                if (osc_edge) begin
                    if (serial_in) begin
                        brk_end = 1'b1;
                        // rising edge after last data, before parity
                        brk_par = cfg.parity_en
                                  && (st_r.pos == nd + 4'h1);
                        perr_set = brk_par;
                        st_nxt.tick = 7'h00;
                        st_nxt.fsm = asrq_pkg::S_IDLE;
                    end else if (st_r.tick == bit_len - 7'h01) begin
                        st_nxt.tick = 7'h00;
                        st_nxt.pos = (st_r.pos == brk_last) ? 4'h0
                                     : st_r.pos + 4'h1;
                    end else begin
                        st_nxt.tick = st_r.tick + 7'h01;
                    end
                end
            end
            default: begin
                st_nxt.fsm = asrq_pkg::S_IDLE;
            end
        endcase

        // two-entry buffer, head always in buf0
        pop = st_r.rdy & rx_ready;
        if (pop) begin
            st_nxt.buf0 = st_r.buf1;
            cnt_tmp = st_r.cnt - 2'h1;
        end
        if (push) begin
            if (cnt_tmp == 2'h0) begin
                st_nxt.buf0 = st_r.pend;
            end else begin
                st_nxt.buf1 = st_r.pend;
            end
            cnt_tmp = cnt_tmp + 2'h1;
        end
        st_nxt.cnt = cnt_tmp;
        st_nxt.rdy = (cnt_tmp != 2'h0);

        // sticky flags; a set in the clearing cycle wins
        st_nxt.perr = perr_set | (st_r.perr & ~err_clr);
        st_nxt.ferr = ferr_set | (st_r.ferr & ~err_clr);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign parity_err = st_r.perr;
    assign framing_err = st_r.ferr;
    assign rx_char_ready = st_r.rdy;
    assign rx_valid = st_r.rdy;
    assign rx_word = st_r.buf0;

    // ******************************************************
    // checks
    // ******************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    short_start_16_a: assert property (
        st_r.fsm == asrq_pkg::S_START && osc_edge && !cfg.mode_64x
        && serial_in && st_r.tick < asrq_pkg::IGN_16
        |=> st_r.fsm == asrq_pkg::S_IDLE && !push)
        else $error("short 16x start not ignored");

    short_start_64_a: assert property (
        st_r.fsm == asrq_pkg::S_START && osc_edge && cfg.mode_64x
        && serial_in && st_r.tick < asrq_pkg::IGN_64
        |=> st_r.fsm == asrq_pkg::S_IDLE)
        else $error("short 64x start not ignored");

    start_qual_16_a: assert property (
        st_r.fsm == asrq_pkg::S_START && osc_edge && !cfg.mode_64x
        && !serial_in && st_r.tick == 7'h08
        |=> st_r.fsm == asrq_pkg::S_DATA && st_r.tick == 7'h00)
        else $error("16x start of nine clocks not accepted");

    start_qual_64_a: assert property (
        st_r.fsm == asrq_pkg::S_START && osc_edge && cfg.mode_64x
        && !serial_in && st_r.tick == 7'h20
        |=> st_r.fsm == asrq_pkg::S_DATA)
        else $error("64x start of 33 clocks not accepted");

    low_run_count_a: assert property (
        st_r.fsm == asrq_pkg::S_START && osc_edge && !serial_in
        && st_r.tick != qual - 7'h01
        |=> st_r.fsm == asrq_pkg::S_START
        && st_r.tick == $past(st_r.tick) + 7'h01)
        else $error("start low run not counted");

    break_parity_a: assert property (
        brk_end && cfg.parity_en && st_r.pos == nd + 4'h1
        |=> parity_err && !rx_valid || $past(st_r.rdy))
        else $error("break before parity did not set flag");

    break_no_char_a: assert property (
        st_r.fsm == asrq_pkg::S_STOP && osc_edge && !serial_in
        && !st_r.ones && st_r.tick == bit_len - 7'h01
        |=> st_r.fsm == asrq_pkg::S_BREAK)
        else $error("break produced a character");

    parity_sticky_a: assert property (
        parity_err && !err_clr |=> parity_err [*2] or err_clr)
        else $error("parity flag dropped without clear");

    break_other_a: assert property (
        brk_end && st_r.pos != nd + 4'h1 && !parity_err && !err_clr
        |=> !parity_err && st_r.cnt == $past(st_r.cnt) - 2'($past(pop)))
        else $error("break elsewhere changed status");

    status_delay_a: assert property (
        perr_set |-> ##[1:28] parity_err)
        else $error("parity status late");

    char_rx_c: cover property (push ##1 rx_valid && rx_ready);
    noise_c: cover property (
        st_r.fsm == asrq_pkg::S_START && osc_edge && serial_in);
    break_par_c: cover property (brk_end && brk_par);
    buf_full_c: cover property (st_r.cnt == asrq_pkg::BUF_DEPTH);

endmodule

`default_nettype wire

// ===== bench/asrq_tx_model.sv
`timescale 1ns/10ps
`default_nettype none

module asrq_tx_model (
    // clock
    input wire logic clk,
    // serial side
    output var logic serial_in,
    output var logic rx_oversample_clock
);
    initial begin
        serial_in = 1'b1;
        rx_oversample_clock = 1'b0;
    end

    // one tick: line set in low phase, stable at the rising edge
    task automatic ticks(input logic lvl, input int n);
        repeat (n) begin
            @(posedge clk);
            serial_in <= lvl;
            rx_oversample_clock <= 1'b0;
            @(posedge clk);
            @(posedge clk);
            rx_oversample_clock <= 1'b1;
            @(posedge clk);
        end
    endtask

    // start is always a full bit, never a half-bit pulse
    task automatic frame(input logic [7:0] d, input int nd, input logic pen,
                         input int blen);
        logic p;
        p = 1'b0;
        ticks(1'b0, blen);
        for (int i = 0; i < nd; i++) begin
            ticks(d[i], blen);
            p = p ^ d[i];
        end
        if (pen) begin
            ticks(p, blen);
        end
        ticks(1'b1, blen * 2);
    endtask
endmodule

`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) compare(64'(a), 64'(b))

module testbench;
    logic clk, sys_rst, err_clr, rx_ready, serial_in, osc;
    logic parity_err, framing_err, rx_char_ready, rx_valid;
    asrq_pkg::asrq_cfg_t cfg;
    asrq_pkg::asrq_char_t rx_word;
    int fails = 0;
    int checked = 0;

    asrq_rx dut_u (.clk(clk), .sys_rst(sys_rst), .serial_in(serial_in),
        .rx_oversample_clock(osc), .cfg(cfg), .err_clr(err_clr),
        .parity_err(parity_err), .framing_err(framing_err),
        .rx_char_ready(rx_char_ready), .rx_word(rx_word),
        .rx_valid(rx_valid), .rx_ready(rx_ready));
    asrq_tx_model tx_u (.clk(clk), .serial_in(serial_in),
        .rx_oversample_clock(osc));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ******************************************************
    // helpers
    // ******************************************************
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic compare(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got,
                     exp);
        end
    endtask

    task automatic set_cfg(input logic m64, input logic pen);
        @(posedge clk);
        cfg <= '{mode_64x: m64, parity_en: pen, parity_odd: 1'b0,
                 data_len: 2'h3};
    endtask

    // bounded wait, then check head word and pop it
    task automatic take(input logic [7:0] d, input logic [1:0] fl);
        int n;
        n = 0;
        // step off the edge so a pop at this edge has settled
        #1;
        while (rx_valid !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 400) begin
            fails++;
            print_verdict();
        end
        `CHK(rx_char_ready, 1'b1);
        `CHK(rx_word, {d, fl});
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask

    task automatic none_seen();
        @(posedge clk);
        #1;
        `CHK({rx_valid, parity_err, framing_err}, 3'h0);
    endtask

    // ******************************************************
    // scenarios
    // ******************************************************
    task automatic t_glitch16();
        set_cfg(1'b0, 1'b0);
        // idle long enough for a wrongly started frame to surface
        tx_u.ticks(1'b0, 6);
        tx_u.ticks(1'b1, 160);
        none_seen();
        tx_u.ticks(1'b0, 5);
        tx_u.ticks(1'b1, 1);
        tx_u.ticks(1'b0, 5);
        tx_u.ticks(1'b1, 160);
        none_seen();
        tx_u.ticks(1'b0, 8);
        tx_u.ticks(1'b1, 160);
        none_seen();
        tx_u.frame(8'hA5, 8, 1'b0, 16);
        take(8'hA5, 2'h0);
    endtask

    task automatic t_glitch64();
        set_cfg(1'b1, 1'b1);
        tx_u.ticks(1'b0, 30);
        tx_u.ticks(1'b1, 700);
        none_seen();
        tx_u.ticks(1'b0, 32);
        tx_u.ticks(1'b1, 700);
        none_seen();
        tx_u.frame(8'h3C, 8, 1'b1, 64);
        take(8'h3C, 2'h0);
    endtask

    // receiver stalls while two words queue up
    task automatic t_fill();
        set_cfg(1'b0, 1'b0);
        tx_u.frame(8'h01, 8, 1'b0, 16);
        tx_u.frame(8'hFE, 8, 1'b0, 16);
        take(8'h01, 2'h0);
        take(8'hFE, 2'h0);
        none_seen();
        // a low parity slot lands where the stop bit is expected
        tx_u.frame(8'h03, 8, 1'b1, 16);
        take(8'h03, 2'h2);
        `CHK({framing_err, parity_err}, 2'h2);
    endtask

    task automatic t_break();
        set_cfg(1'b0, 1'b1);
        // line rises mid-slot between last data and parity
        tx_u.ticks(1'b0, 320);
        tx_u.ticks(1'b1, 7);
        #1;
        `CHK({parity_err, rx_valid}, 2'h2);
        tx_u.ticks(1'b1, 32);
        tx_u.frame(8'h5A, 8, 1'b1, 16);
        take(8'h5A, 2'h0);
        `CHK(parity_err, 1'b1);
        @(posedge clk);
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
        none_seen();
        // rise in an earlier slot, the third data slot, leaves no trace
        tx_u.ticks(1'b0, 224);
        tx_u.ticks(1'b1, 40);
        none_seen();
    endtask

    initial begin
        sys_rst = 1'b1;
        err_clr = 1'b0;
        rx_ready = 1'b0;
        cfg = '0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        none_seen();
        t_glitch16();
        t_glitch64();
        t_fill();
        t_break();
        print_verdict();
    end
endmodule

`default_nettype wire
